// ### design/sfr_pkg.sv
// shared constants for the serial flash array read link
package sfr_pkg;
   localparam logic [7:0] OPC_LEGACY_READ = 8'he8;
   localparam logic [7:0] OPC_FAST_READ = 8'h1b;
   localparam int OPCODE_BITS = 8;
   localparam int ADDR_BITS = 24;
   localparam int DUMMY_BYTES_LEGACY = 4;
   localparam int DUMMY_BYTES_FAST = 2;
   localparam int PAGE_BYTES_WIDE = 264;
   localparam int PAGE_BYTES_NARROW = 256;
   localparam int PAGE_COUNT = 4096;
   localparam int PAGE_W = 12;
   localparam int BYTE_W = 9;
   localparam int WIDE_PAGE_LSB = 9;
   localparam int NARROW_PAGE_LSB = 8;
   localparam int NARROW_BYTE_W = 8;
   localparam int SYS_CLK_PERIOD_NS = 10;
   localparam int SCK_PERIOD_NS = 160;
   localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
   localparam logic CS_IDLE = 1'b1;
   localparam logic SO_PULL_LEVEL = 1'b1;
endpackage : sfr_pkg

// ### design/sfr_link_if.sv
// serial link between host master and flash device
`timescale 1ns/1ps
interface sfr_link_if;
   import sfr_pkg::*;
   logic csN;
   logic sck;
   logic si;
   logic soOut;
   logic soOe;
   logic soLine;
   // released output reads as the pull-up level
   assign soLine = soOe ? soOut : SO_PULL_LEVEL;
   modport device (
      input csN,
      input sck,
      input si,
      output soOut,
      output soOe
   );
   modport host (
      output csN,
      output sck,
      output si,
      input soLine
   );
endinterface : sfr_link_if

// ### design/sfr_array_mem.sv
// main array storage with a load port and an asynchronous read port
`timescale 1ns/1ps
module sfr_array_mem #(
   parameter int DEPTH = 1024,
   parameter int IDX_W = 10
) (
   input wire logic sys_clk,
   input wire logic wrEn,
   input wire logic [IDX_W-1:0] wrIdx,
   input wire logic [7:0] wrData,
   input wire logic [IDX_W-1:0] rdIdx,
   output logic [7:0] rdData
);
   logic [7:0] mem [DEPTH];

   if (DEPTH < 2 || (2 ** IDX_W) < DEPTH)
   begin : g_chk
      $error("sfr_array_mem: index too narrow for depth");
   end

   always_ff @(posedge sys_clk)
   begin
      if (wrEn && (int'(wrIdx) < DEPTH))
      begin
         mem[wrIdx] <= wrData;
      end
   end

   // out of range reads return zero rather than alias
   assign rdData = (int'(rdIdx) < DEPTH) ? mem[rdIdx] : 8'h00;
endmodule : sfr_array_mem

// ### design/sfr_device.sv
// flash device end: command decode and continuous main array read
`timescale 1ns/1ps
module sfr_device
   import sfr_pkg::*;
#(
   parameter int PAGES = PAGE_COUNT,
   localparam int IDX_W = $clog2(PAGES * PAGE_BYTES_WIDE)
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   sfr_link_if.device link,
   input wire logic pageSize264,
   input wire logic memWrEn,
   input wire logic [IDX_W-1:0] memWrIdx,
   input wire logic [7:0] memWrData,
   output logic readActive
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_CMD = 5'b00010,
      ST_ADDR = 5'b00100,
      ST_DUMMY = 5'b01000,
      ST_DATA = 5'b10000
   } sfr_dev_state_e;

   if (PAGES < 2 || PAGES > PAGE_COUNT)
   begin : g_chk
      $error("sfr_device: PAGES out of range");
   end

   logic csS1_q, csS2_q, csPrev_q;
   logic sckS1_q, sckS2_q, sckPrev_q;
   logic siS1_q, siS2_q;
   sfr_dev_state_e state_q;
   logic [5:0] bitCnt_q;
   logic [5:0] dummyBits_q;
   logic [ADDR_BITS-1:0] shift_q;
   logic [PAGE_W-1:0] page_q;
   logic [BYTE_W-1:0] byte_q;
   logic [7:0] outByte_q;
   logic [2:0] outBit_q;
   logic soOut_q, soOe_q, readActive_q;

   logic selected, csFall, sckRise, sckFall;
   logic addrDone, dummyDone, byteDone;
   logic [ADDR_BITS-1:0] fullAddr;
   logic [PAGE_W-1:0] startPage, nextPage;
   logic [BYTE_W-1:0] startByte, nextByte, lastByte;
   logic [IDX_W-1:0] memIdx;
   logic [7:0] memData;

   // pins are asynchronous to sys_clk; first stage feeds only the second
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         csS1_q <= CS_IDLE;
         csS2_q <= CS_IDLE;
         csPrev_q <= CS_IDLE;
         sckS1_q <= 1'b0;
         sckS2_q <= 1'b0;
         sckPrev_q <= 1'b0;
         siS1_q <= 1'b0;
         siS2_q <= 1'b0;
      end
      else
      begin
         csS1_q <= link.csN;
         csS2_q <= csS1_q;
         csPrev_q <= csS2_q;
         sckS1_q <= link.sck;
         sckS2_q <= sckS1_q;
         sckPrev_q <= sckS2_q;
         siS1_q <= link.si;
         siS2_q <= siS1_q;
      end
   end

   assign selected = ~csS2_q;
   assign csFall = ~csS2_q & csPrev_q;
   // edge detectors work for either idle level of the clock
   assign sckRise = sckS2_q & ~sckPrev_q;
   assign sckFall = ~sckS2_q & sckPrev_q;

   assign fullAddr = {shift_q[ADDR_BITS-2:0], siS2_q};
   // leading address bits above the used field are dropped
   assign startPage = pageSize264 ? fullAddr[WIDE_PAGE_LSB +: PAGE_W]
                                  : fullAddr[NARROW_PAGE_LSB +: PAGE_W];
   assign startByte = pageSize264 ? fullAddr[BYTE_W-1:0]
                                  : {1'b0, fullAddr[NARROW_BYTE_W-1:0]};
   assign lastByte = pageSize264 ? BYTE_W'(PAGE_BYTES_WIDE - 1)
                                 : BYTE_W'(PAGE_BYTES_NARROW - 1);

   // page crossover and array wrap happen in the same cycle as any step
   always_comb
   begin
      if (byte_q >= lastByte)
      begin
         nextByte = '0;
         nextPage = (page_q >= PAGE_W'(PAGES - 1)) ? '0 : page_q + 1'b1;
      end
      else
      begin
         nextByte = byte_q + 1'b1;
         nextPage = page_q;
      end
   end

   // both sizes use the wide stride so the array never moves
   assign memIdx = IDX_W'(page_q) * IDX_W'(PAGE_BYTES_WIDE) + IDX_W'(byte_q);

   // read only path; no buffer exists or is written here
   sfr_array_mem #(
      .DEPTH(PAGES * PAGE_BYTES_WIDE),
      .IDX_W(IDX_W)
   ) u_mem (
      .sys_clk(sys_clk),
      .wrEn(memWrEn),
      .wrIdx(memWrIdx),
      .wrData(memWrData),
      .rdIdx(memIdx),
      .rdData(memData)
   );

   assign addrDone = selected & sckRise & (state_q == ST_ADDR)
                     & (bitCnt_q == 6'(ADDR_BITS - 1));
   assign dummyDone = selected & sckRise & (state_q == ST_DUMMY)
                      & (bitCnt_q == dummyBits_q - 1'b1);
   assign byteDone = selected & sckFall & (state_q == ST_DATA) & (outBit_q == 3'h7);

   // frame sequencer
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !selected)
      begin
         state_q <= ST_IDLE;
         bitCnt_q <= '0;
         shift_q <= '0;
         dummyBits_q <= '0;
      end
      else if (csFall)
      begin
         state_q <= ST_CMD;
         bitCnt_q <= '0;
      end
      else if (sckRise)
      begin
         shift_q <= {shift_q[ADDR_BITS-2:0], siS2_q};
         bitCnt_q <= bitCnt_q + 1'b1;
         case (state_q)
            ST_CMD:
            begin
               if (bitCnt_q == 6'(OPCODE_BITS - 1))
               begin
                  bitCnt_q <= '0;
                  // unknown opcodes park until deselect
                  if (fullAddr[7:0] == OPC_LEGACY_READ)
                  begin
                     state_q <= ST_ADDR;
                     dummyBits_q <= 6'(DUMMY_BYTES_LEGACY * 8);
                  end
                  else if (fullAddr[7:0] == OPC_FAST_READ)
                  begin
                     state_q <= ST_ADDR;
                     dummyBits_q <= 6'(DUMMY_BYTES_FAST * 8);
                  end
                  else
                  begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_ADDR:
            begin
               if (addrDone)
               begin
                  state_q <= ST_DUMMY;
                  bitCnt_q <= '0;
               end
            end
            ST_DUMMY:
            begin
               if (dummyDone)
               begin
                  state_q <= ST_DATA;
                  bitCnt_q <= '0;
               end
            end
            ST_DATA:
            begin
               bitCnt_q <= '0;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // address counter and output shifter
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         page_q <= '0;
         byte_q <= '0;
         outByte_q <= '0;
         outBit_q <= '0;
      end
      else if (addrDone)
      begin
         page_q <= startPage;
         byte_q <= startByte;
      end
      else if (dummyDone || byteDone)
      begin
         // preload next byte so the stream has no gap
         outByte_q <= memData;
         outBit_q <= '0;
         page_q <= nextPage;
         byte_q <= nextByte;
      end
      else if (selected && sckFall && state_q == ST_DATA)
      begin
         outByte_q <= {outByte_q[6:0], 1'b0};
         outBit_q <= outBit_q + 1'b1;
      end
   end

   // output pin: driven only from the first data fall until deselect
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !selected)
      begin
         soOut_q <= 1'b0;
         soOe_q <= 1'b0;
      end
      else if (sckFall && state_q == ST_DATA)
      begin
         soOut_q <= outByte_q[7];
         soOe_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         readActive_q <= 1'b0;
      end
      else
      begin
         readActive_q <= selected & (state_q == ST_DATA);
      end
   end

   assign link.soOut = soOut_q;
   assign link.soOe = soOe_q;
   assign readActive = readActive_q;
endmodule : sfr_device

// ### design/sfr_host.sv
// host master end: builds read frames and collects streamed bytes
`timescale 1ns/1ps
module sfr_host
   import sfr_pkg::*;
#(
   parameter int SCK_HALF = SCK_HALF_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   sfr_link_if.host link,
   input wire logic mode3,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [ADDR_BITS-1:0] startAddr,
   input wire logic [15:0] byteCount,
   output logic busy,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic done
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_RUN = 3'b010,
      H_TAIL = 3'b100
   } sfr_host_state_e;

   // device needs three sys_clk cycles from fall to valid output, five to the host sampler
   if (SCK_HALF < 8 || SCK_HALF > 65535)
   begin : g_chk
      $error("sfr_host: SCK_HALF out of range");
   end

   sfr_host_state_e state_q;
   logic soS1_q, soS2_q;
   logic [15:0] halfCnt_q;
   logic [19:0] bitCnt_q, totalBits_q, txBits_q;
   logic [63:0] txShift_q;
   logic [7:0] rxShift_q, rdData_q;
   logic csN_q, sck_q, mosi_q, busy_q, rdValid_q, done_q;
   logic halfEnd;
   logic [19:0] txBits;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         soS1_q <= 1'b0;
         soS2_q <= 1'b0;
      end
      else
      begin
         soS1_q <= link.soLine;
         soS2_q <= soS1_q;
      end
   end

   assign halfEnd = (halfCnt_q == 16'(SCK_HALF - 1));
   // legacy read kept for old parts; fast read needs fewer dummy clocks
   assign txBits = (opcode == OPC_LEGACY_READ)
                   ? 20'(OPCODE_BITS + ADDR_BITS + DUMMY_BYTES_LEGACY * 8)
                   : 20'(OPCODE_BITS + ADDR_BITS + DUMMY_BYTES_FAST * 8);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_q <= H_IDLE;
         halfCnt_q <= '0;
         bitCnt_q <= '0;
         totalBits_q <= '0;
         txBits_q <= '0;
         txShift_q <= '0;
         rxShift_q <= '0;
         rdData_q <= '0;
         csN_q <= CS_IDLE;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         busy_q <= 1'b0;
         rdValid_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         rdValid_q <= 1'b0;
         done_q <= 1'b0;
         halfCnt_q <= halfEnd ? '0 : halfCnt_q + 1'b1;
         case (state_q)
            H_IDLE:
            begin
               sck_q <= mode3;
               halfCnt_q <= '0;
               if (start)
               begin
                  state_q <= H_RUN;
                  csN_q <= 1'b0;
                  sck_q <= 1'b0;
                  busy_q <= 1'b1;
                  txShift_q <= {opcode, startAddr, 32'h0};
                  mosi_q <= opcode[7];
                  txBits_q <= txBits;
                  totalBits_q <= txBits + {1'b0, byteCount, 3'h0};
                  bitCnt_q <= '0;
               end
            end
            H_RUN:
            begin
               if (halfEnd && !sck_q)
               begin
                  sck_q <= 1'b1;
                  if (bitCnt_q >= txBits_q)
                  begin
                     rxShift_q <= {rxShift_q[6:0], soS2_q};
                     if (bitCnt_q[2:0] == 3'h7)
                     begin
                        rdData_q <= {rxShift_q[6:0], soS2_q};
                        rdValid_q <= 1'b1;
                     end
                  end
               end
               else if (halfEnd)
               begin
                  if (bitCnt_q == totalBits_q - 1'b1)
                  begin
                     state_q <= H_TAIL;
                     sck_q <= mode3;
                  end
                  else
                  begin
                     sck_q <= 1'b0;
                     bitCnt_q <= bitCnt_q + 1'b1;
                     txShift_q <= {txShift_q[62:0], 1'b0};
                     mosi_q <= (bitCnt_q + 1'b1 < txBits_q) ? txShift_q[62] : 1'b0;
                  end
               end
            end
            H_TAIL:
            begin
               // select held low through the whole frame
               if (halfEnd)
               begin
                  csN_q <= CS_IDLE;
                  state_q <= H_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  mosi_q <= 1'b0;
               end
            end
            default:
            begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   assign link.csN = csN_q;
   assign link.sck = sck_q;
   assign link.si = mosi_q;
   assign busy = busy_q;
   assign rdData = rdData_q;
   assign rdValid = rdValid_q;
   assign done = done_q;
endmodule : sfr_host

// ### dv/sfr_link_assertions.sv
// concurrent checks on the host to device serial link
`timescale 1ns/1ps
module sfr_link_assertions
   import sfr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   input wire logic soOut,
   input wire logic soOe,
   input wire logic soLine
);
   logic sck_q;
   logic [15:0] riseCnt_q;
   logic [7:0] opcode_q;
   logic [2:0] idleCnt_q;
   // pin-level edge finder, one flop on the raw pin rather than the device's two-stage synchronizer
   always_ff @(posedge sys_clk)
   begin
      sck_q <= sys_rst ? 1'b0 : sck;
   end
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || csN)
         riseCnt_q <= 16'h0000;
      else if (sck && !sck_q)
         riseCnt_q <= riseCnt_q + 16'h0001;
   end
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         opcode_q <= 8'h00;
      else if (!csN && sck && !sck_q && riseCnt_q < 16'h0008)
         opcode_q <= {opcode_q[6:0], si};
   end
   // saturates: only the first cycles after deselect matter
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !csN)
         idleCnt_q <= 3'h0;
      else if (idleCnt_q != 3'h7)
         idleCnt_q <= idleCnt_q + 3'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   release_out_a: assert property (idleCnt_q >= 3'h5 |-> !soOe)
      else $error("output still driven after deselect");
   frame_len_a: assert property ($rose(soOe) |->
      (opcode_q == OPC_LEGACY_READ && riseCnt_q == 16'h0040) ||
      (opcode_q == OPC_FAST_READ && riseCnt_q == 16'h0030))
      else $error("data phase began after wrong header length");
   refuse_op_a: assert property (riseCnt_q > 16'h0008 && opcode_q != OPC_LEGACY_READ
      && opcode_q != OPC_FAST_READ |-> !soOe)
      else $error("output driven for unsupported opcode");
   stream_hold_a: assert property (soOe && !csN |=> soOe)
      else $error("stream stopped while selected");
   out_edge_a: assert property (soOe && $changed(soOut) |-> !sck && !$past(sck, 2))
      else $error("output changed outside falling clock");
   in_edge_a: assert property (!csN && $changed(si) |-> !sck)
      else $error("input changed while clock high");
   half_high_a: assert property ($rose(sck) && !csN |-> sck [*8])
      else $error("clock high phase too short");
   half_low_a: assert property ($fell(sck) && !csN |-> !sck [*8])
      else $error("clock low phase too short");
   cs_gap_a: assert property ($rose(csN) |-> csN [*4])
      else $error("select gap too short");
   cover property ($rose(soOe) && opcode_q == OPC_LEGACY_READ);
   cover property ($rose(soOe) && opcode_q == OPC_FAST_READ);
   cover property (riseCnt_q == 16'h0010 && opcode_q != OPC_FAST_READ
      && opcode_q != OPC_LEGACY_READ);
endmodule : sfr_link_assertions

// ### dv/serial_flash_array_read_test.sv
// self-checking bench joining the host and device ends over the link
`timescale 1ns/1ps
module serial_flash_array_read_test;
   import sfr_pkg::*;
   // four pages keep the wrap test short
   localparam int PG = 4;
   localparam int IW = $clog2(PG * PAGE_BYTES_WIDE);
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pageSize264 = 1'b1;
   logic memWrEn = 1'b0;
   logic [IW-1:0] memWrIdx = '0;
   logic [7:0] memWrData = 8'h00;
   logic mode3 = 1'b0;
   logic start = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [ADDR_BITS-1:0] startAddr = '0;
   logic [15:0] byteCount = 16'h0000;
   logic readActive;
   logic busy;
   logic rdValid;
   logic done;
   logic [7:0] rdData;
   int err_total = 0;
   int n_checks = 0;
   sfr_link_if lnk ();
   sfr_device #(.PAGES(PG)) u_sfr_device (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(lnk.device), .pageSize264(pageSize264), .memWrEn(memWrEn), .memWrIdx(memWrIdx),
      .memWrData(memWrData), .readActive(readActive));
   sfr_host u_sfr_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lnk.host), .mode3(mode3),
      .start(start), .opcode(opcode), .startAddr(startAddr), .byteCount(byteCount),
      .busy(busy), .rdData(rdData), .rdValid(rdValid), .done(done));
   sfr_link_assertions u_sfr_link_assertions (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .csN(lnk.csN), .sck(lnk.sck), .si(lnk.si), .soOut(lnk.soOut), .soOe(lnk.soOe),
      .soLine(lnk.soLine));
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] pat(input int idx);
      return 8'(idx * 37 + (idx >> 8) + 5);
   endfunction : pat
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   // one whole frame; unknown opcodes must read as the released line
   task automatic rd(input logic [7:0] op, input logic p264, input logic m3, input int page,
      input int byt, input int n);
      int pg;
      int by;
      int got;
      int w;
      logic [7:0] e;
      logic [23:0] a;
      logic act;
      pg = page;
      by = byt;
      got = 0;
      act = 1'b0;
      a = p264 ? 24'(page * 512 + byt) : 24'(page * 256 + byt);
      a[23:21] = 3'h7;
      @(posedge sys_clk);
      pageSize264 <= p264;
      mode3 <= m3;
      repeat (4) @(posedge sys_clk);
      opcode <= op;
      startAddr <= a;
      byteCount <= 16'(n);
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      for (w = 0; w < 40000 && done !== 1'b1; w++)
      begin
         @(posedge sys_clk);
         // data phase flag from the device end, seen at least once per known read
         if (readActive === 1'b1)
            act = 1'b1;
         if (rdValid === 1'b1)
         begin
            e = (op == OPC_LEGACY_READ || op == OPC_FAST_READ) ? pat(pg * 264 + by) : 8'hff;
            check("read byte", e, rdData);
            check("busy in frame", 8'h01, {7'h00, busy});
            by++;
            got++;
            if (by == (p264 ? PAGE_BYTES_WIDE : PAGE_BYTES_NARROW))
            begin
               by = 0;
               pg = (pg + 1) % PG;
            end
         end
      end
      if (done !== 1'b1)
      begin
         check("frame done", 8'h01, 8'h00);
         results();
      end
      else
      begin
         check("byte count", 8'(n), 8'(got));
         check("busy after frame", 8'h00, {7'h00, busy});
         e = (op == OPC_LEGACY_READ || op == OPC_FAST_READ) ? 8'h01 : 8'h00;
         check("data phase seen", e, {7'h00, act});
      end
   endtask : rd
   initial
   begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // array is not reset, so fill every location first
      for (int i = 0; i < PG * PAGE_BYTES_WIDE; i++)
      begin
         @(posedge sys_clk);
         memWrEn <= 1'b1;
         memWrIdx <= IW'(i);
         memWrData <= pat(i);
      end
      @(posedge sys_clk);
      memWrEn <= 1'b0;
      rd(OPC_FAST_READ, 1'b1, 1'b0, 0, 260, 8);
      rd(OPC_LEGACY_READ, 1'b1, 1'b1, 3, 262, 4);
      rd(OPC_FAST_READ, 1'b0, 1'b1, 1, 254, 4);
      rd(OPC_LEGACY_READ, 1'b0, 1'b0, 3, 254, 4);
      rd(8'h03, 1'b0, 1'b0, 0, 0, 2);
      rd(OPC_FAST_READ, 1'b1, 1'b1, 2, 0, 1);
      results();
   end
endmodule : serial_flash_array_read_test
